//--- hdl/upgrade_wd_map.svh
// Offsets, field positions, reset values and timing counts of the upgrade watchdog.
`ifndef UPGRADE_WD_MAP_SVH
`define UPGRADE_WD_MAP_SVH
`define WD_CNT_W 29
`define WD_SET_W 12
`define WD_GRAN_BITS 17
`define IN_SEL_BIT 13
`define IN_OVR_BIT 12
`define SR_W 41
`define REG_W 39
`define ST_CODE_HI 33
`define ST_CODE_LO 30
`define ST_WDEN_BIT 29
`define PV_SRC_HI 31
`define PV_SRC_LO 28
`define PV_CODE_HI 25
`define PV_CODE_LO 22
`define LD_IMG0 4'h2
`define LD_IMG1_REVERT 4'h3
`define LD_IMG1 4'h4
`define LD_IMG0_REVERT 4'h5
`define RESTART_MIN_NS 250
`define CLK_PERIOD_NS 100
`define RESTART_MIN_CYC ((`RESTART_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OSC_DIV_DEF 1
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h1
`define ADDR_CUR 4'h2
`define ADDR_PREV 4'h3
`define ADDR_IRQ_ST 4'h4
`define ADDR_IRQ_MASK 4'h5
`define ADDR_INREG 4'h6
`define CTRL_WDEN_BIT 0
`define CTRL_TIMEOUT_LO 4
`define CTRL_IMG_BIT 16
`define CTRL_USER_BIT 17
`define CTRL_RST 32'h00000001
`endif

//--- hdl/upgrade_wd_pkg.sv
// Types of the upgrade watchdog block.
package upgrade_wd_pkg;
	typedef enum logic [4:0]
	{
		LD_IDLE = 5'h01,
		LD_IMAGE = 5'h02,
		LD_USER = 5'h04,
		LD_REVERT = 5'h08,
		LD_DONE = 5'h10
	} loader_state_t;
	typedef struct packed
	{
		logic [31:0] wdata;
		logic [3:0] addr;
		logic wr;
		logic rd;
	} reg_req_t;
	typedef struct packed
	{
		logic shift_not_load;
		logic capture_not_update;
		logic din;
	} upg_ctl_t;
endpackage

//--- hdl/restart_filter.sv
// Synchroniser and minimum-width check for the watchdog restart pulse.
`timescale 1ns/1ps
`include "upgrade_wd_map.svh"
module restart_filter
	import upgrade_wd_pkg::*;
#(
	parameter int MIN_CYC = `RESTART_MIN_CYC
)
(
	input wire logic clk, // System clock.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic pin_n, // Restart pin, active low, asynchronous.
	output logic restart // One-cycle pulse after a valid low pulse ends.
);
	logic s1_r;
	logic s2_r;
	logic [7:0] len_r;
	wire long_enough = (len_r >= 8'(MIN_CYC));
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			len_r <= 8'h00;
			restart <= 1'b0;
		end
		else
		begin
			s1_r <= pin_n;
			s2_r <= s1_r;
			restart <= s2_r && long_enough;
			if (!s2_r)
				len_r <= (len_r == 8'hFF) ? len_r : len_r + 8'h01;
			else
				len_r <= 8'h00;
		end
	end
endmodule // restart_filter

//--- hdl/osc_divider.sv
// Internal oscillator tick: one-cycle enable pulse every DIV cycles.
`timescale 1ns/1ps
`include "upgrade_wd_map.svh"
module osc_divider
	import upgrade_wd_pkg::*;
#(
	parameter int DIV = `OSC_DIV_DEF
)
(
	input wire logic clk, // System clock.
	input wire logic rst_n, // Synchronous reset, active low.
	output logic tick // One-cycle oscillator enable.
);
	logic [15:0] cnt_r;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cnt_r <= 16'h0000;
			tick <= 1'b0;
		end
		else if (cnt_r >= 16'(DIV - 1))
		begin
			cnt_r <= 16'h0000;
			tick <= 1'b1;
		end
		else
		begin
			cnt_r <= cnt_r + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule // osc_divider

//--- hdl/image_upgrade_watchdog.sv
// Remote upgrade supervisor: image loader tracking, user watchdog and status shift chain.
`timescale 1ns/1ps
`include "upgrade_wd_map.svh"
module image_upgrade_watchdog
	import upgrade_wd_pkg::*;
#(
	parameter int OSC_DIV = `OSC_DIV_DEF,
	parameter int LOAD_CYC = 16
)
(
	input wire logic clk, // System clock, 10 MHz.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic [3:0] addr, // Register address.
	input wire logic [31:0] wdata, // Write data.
	input wire logic wr, // Write strobe.
	input wire logic rd, // Read strobe.
	output logic [31:0] rdata, // Read data, one cycle after rd.
	input wire logic watchdog_restart_n, // Restart pulse pin, active low.
	input wire logic reconfig_request_n, // Reconfiguration request pin, active low.
	input wire logic image_select, // Image select pin.
	input wire logic crc_error_in, // CRC error source pin.
	input wire logic status_fault_n, // Status fault source pin, active low.
	input wire logic shift_not_load, // Chain control: shift.
	input wire logic capture_not_update, // Chain control: capture or update.
	input wire logic shift_din, // Chain serial data in.
	output logic shift_dout, // Chain serial data out.
	output logic watchdog_timeout, // Timeout indication, one-cycle pulse.
	output logic [3:0] loader_state_code, // Current loader state code.
	output logic irq // Interrupt, level.
);
	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [5:0] pin_s1_r;
	logic [5:0] pin_s2_r;
	wire [5:0] pin_raw = {reconfig_request_n, image_select, crc_error_in, status_fault_n,
		shift_not_load, capture_not_update};
	logic din_s1_r;
	logic din_s2_r;
	// The synchronisers keep running through reset, so the image select pin is settled
	// by the time the loader leaves idle and picks the first image.
	always_ff @(posedge clk)
	begin
		pin_s1_r <= pin_raw;
		pin_s2_r <= pin_s1_r;
		din_s1_r <= shift_din;
		din_s2_r <= din_s1_r;
	end
	upg_ctl_t ctl;
	assign ctl = '{shift_not_load: pin_s2_r[1], capture_not_update: pin_s2_r[0],
		din: din_s2_r};
	wire reconfig_lvl_n = pin_s2_r[5];
	wire img_pin = pin_s2_r[4];
	wire crc_lvl = pin_s2_r[3];
	wire fault_lvl_n = pin_s2_r[2];
	logic reconfig_d_r;
	logic crc_d_r;
	logic fault_d_r;
	wire reconfig_ev = !reconfig_lvl_n && !reconfig_d_r;
	wire crc_ev = crc_lvl && !crc_d_r;
	wire fault_ev = !fault_lvl_n && !fault_d_r;
	// ----------------------------------------------------------------
	// Oscillator tick and restart filter
	// ----------------------------------------------------------------
	logic osc_tick;
	logic restart_p;
	osc_divider #(.DIV(OSC_DIV)) u_osc
	(
		.clk(clk),
		.rst_n(rst_n),
		.tick(osc_tick)
	);
	restart_filter #(.MIN_CYC(`RESTART_MIN_CYC)) u_rst
	(
		.clk(clk),
		.rst_n(rst_n),
		.pin_n(watchdog_restart_n),
		.restart(restart_p)
	);
	// ----------------------------------------------------------------
	// Registers and loader state
	// ----------------------------------------------------------------
	reg_req_t req;
	assign req = '{wdata: wdata, addr: addr, wr: wr, rd: rd};
	logic [31:0] ctrl_r;
	logic [3:0] irq_st_r;
	logic [3:0] irq_mask_r;
	logic [`REG_W-1:0] in_r;
	logic [`SR_W-1:0] sr_r;
	logic [31:0] prev_r;
	logic [`WD_CNT_W-1:0] wd_cnt_r;
	logic [3:0] code_r;
	logic cur_img_r;
	logic app_reset_r;
	loader_state_t state_r;
	loader_state_t state_nxt;
	logic [7:0] load_cnt_r;
	wire wd_en = ctrl_r[`CTRL_WDEN_BIT];
	wire [`WD_SET_W-1:0] wd_set = ctrl_r[`CTRL_TIMEOUT_LO +: `WD_SET_W];
	wire [`WD_CNT_W-1:0] wd_limit = {wd_set, {`WD_GRAN_BITS{1'b0}}};
	wire in_user = (state_r == LD_USER);
	wire wd_expire = in_user && wd_en && osc_tick && (wd_cnt_r >= wd_limit);
	wire any_src = reconfig_ev || crc_ev || fault_ev || wd_expire;
	wire override = in_r[`IN_OVR_BIT];
	wire next_img = override ? in_r[`IN_SEL_BIT] : img_pin;
	wire load_done = (load_cnt_r == 8'(LOAD_CYC - 1));
	// Highest-order source wins when several fire together.
	wire [3:0] src_vec = reconfig_ev ? 4'h8 : crc_ev ? 4'h4 : fault_ev ? 4'h2 : 4'h1;
	wire [3:0] code_norm = next_img ? `LD_IMG1 : `LD_IMG0;
	wire [3:0] code_rev = cur_img_r ? `LD_IMG0_REVERT : `LD_IMG1_REVERT;
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			LD_IDLE: state_nxt = LD_IMAGE;
			LD_IMAGE: if (load_done) state_nxt = LD_USER;
			LD_USER: if (wd_expire) state_nxt = LD_REVERT;
				else if (any_src) state_nxt = LD_IMAGE;
			LD_REVERT: if (load_done) state_nxt = LD_USER;
			LD_DONE: state_nxt = LD_IDLE;
			default: state_nxt = LD_IDLE;
		endcase
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_r <= LD_IDLE;
			load_cnt_r <= 8'h00;
			code_r <= 4'h0;
			cur_img_r <= 1'b0;
			prev_r <= 32'h00000000;
			app_reset_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			app_reset_r <= (state_r != LD_USER) && (state_nxt == LD_USER);
			if (state_nxt != state_r)
				load_cnt_r <= 8'h00;
			else
				load_cnt_r <= load_cnt_r + 8'h01;
			if ((state_r == LD_IDLE) || (in_user && any_src && !wd_expire))
			begin
				code_r <= code_norm;
				cur_img_r <= next_img;
			end
			else if (wd_expire)
			begin
				code_r <= code_rev;
				cur_img_r <= !cur_img_r;
			end
			if (in_user && any_src)
			begin
				prev_r <= 32'h00000000;
				prev_r[`PV_SRC_HI:`PV_SRC_LO] <= src_vec;
				prev_r[`PV_CODE_HI:`PV_CODE_LO] <= code_r;
			end
		end
	end
	// ----------------------------------------------------------------
	// Watchdog counter
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n || !in_user || restart_p || wd_expire)
			wd_cnt_r <= '0;
		else if (osc_tick && wd_en && (wd_cnt_r != '1))
			wd_cnt_r <= wd_cnt_r + 29'h00000001;
	end
	// ----------------------------------------------------------------
	// Status shift chain
	// ----------------------------------------------------------------
	wire [`REG_W-1:0] cur_stat = {1'b0, 4'h0, code_r, wd_en, wd_cnt_r};
	wire [`REG_W-1:0] prev_stat = {7'h00, prev_r};
	wire [`REG_W-1:0] cap_val = (sr_r[40:39] == 2'b00) ? cur_stat :
		(sr_r[40:39] == 2'b11) ? in_r : prev_stat;
	always_ff @(posedge clk)
	begin
		if (!rst_n || app_reset_r)
		begin
			sr_r <= '0;
			in_r <= '0;
		end
		else if (ctl.shift_not_load)
			sr_r <= {sr_r[40:39], ctl.din, sr_r[38:1]};
		else if (ctl.capture_not_update)
			sr_r[`REG_W-1:0] <= cap_val;
		else
			in_r <= sr_r[`REG_W-1:0] & 39'h0000003000;
	end
	// ----------------------------------------------------------------
	// Register bus and interrupts
	// ----------------------------------------------------------------
	wire sel_ctrl = req.wr && (req.addr == `ADDR_CTRL);
	wire sel_ist = req.wr && (req.addr == `ADDR_IRQ_ST);
	wire sel_msk = req.wr && (req.addr == `ADDR_IRQ_MASK);
	wire [3:0] ev_vec = {reconfig_ev, crc_ev, fault_ev, wd_expire};
	wire [31:0] stat_word = {26'h0, cur_img_r, in_user, code_r};
	wire [31:0] rd_mux = (req.addr == `ADDR_CTRL) ? ctrl_r :
		(req.addr == `ADDR_STATUS) ? stat_word :
		(req.addr == `ADDR_CUR) ? cur_stat[31:0] :
		(req.addr == `ADDR_PREV) ? prev_r :
		(req.addr == `ADDR_IRQ_ST) ? {28'h0, irq_st_r} :
		(req.addr == `ADDR_IRQ_MASK) ? {28'h0, irq_mask_r} :
		(req.addr == `ADDR_INREG) ? in_r[31:0] : 32'h00000000;
	always_ff @(posedge clk)
	begin
		if (!rst_n || app_reset_r)
			ctrl_r <= `CTRL_RST;
		else if (sel_ctrl)
			ctrl_r <= req.wdata;
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			irq_st_r <= 4'h0;
			irq_mask_r <= 4'h0;
			rdata <= 32'h00000000;
			irq <= 1'b0;
			watchdog_timeout <= 1'b0;
			loader_state_code <= 4'h0;
			shift_dout <= 1'b0;
			reconfig_d_r <= 1'b0;
			crc_d_r <= 1'b0;
			fault_d_r <= 1'b0;
		end
		else
		begin
			irq_st_r <= (irq_st_r & ~(sel_ist ? req.wdata[3:0] : 4'h0)) | ev_vec;
			if (sel_msk)
				irq_mask_r <= req.wdata[3:0];
			rdata <= req.rd ? rd_mux : 32'h00000000;
			irq <= |(irq_st_r & irq_mask_r);
			watchdog_timeout <= wd_expire;
			loader_state_code <= code_r;
			shift_dout <= sr_r[0];
			reconfig_d_r <= !reconfig_lvl_n;
			crc_d_r <= crc_lvl;
			fault_d_r <= !fault_lvl_n;
		end
	end
endmodule // image_upgrade_watchdog

//--- dv/image_upgrade_watchdog_chk.sv
// Port checker of the upgrade watchdog.
`timescale 1ns/1ps
module image_upgrade_watchdog_chk
#(
	parameter int LOAD_CYC = 16
)
(
	input wire logic clk, // Clock.
	input wire logic rst_n, // Reset.
	input wire logic reconfig_request_n, // Reconfiguration request pin.
	input wire logic wr, // Write.
	input wire logic rd, // Read.
	input wire logic [31:0] rdata, // Read data.
	input wire logic watchdog_timeout, // Expiry.
	input wire logic [3:0] loader_state_code, // Code.
	input wire logic irq // Interrupt.
);
	logic [7:0] gap_r;
	logic [7:0] gap_nxt;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Cycles since the last expiry or reconfiguration request, saturating.
	assign gap_nxt = watchdog_timeout ? 8'h00 : gap_r + {7'h00, gap_r != 8'hFF};
	always_ff @(posedge clk)
		gap_r <= (rst_n && reconfig_request_n) ? gap_nxt : 8'h00;
	chk_rdata_idle: assert property (!rd |=> rdata == 32'h0)
		else $error("rdata not idle");
	chk_timeout_gap: assert property (watchdog_timeout |=> !watchdog_timeout [*8])
		else $error("expiry too soon");
	chk_boot_quiet: assert property ($rose(rst_n) |-> !watchdog_timeout [*8])
		else $error("expiry while loading");
	chk_code_legal: assert property (
		loader_state_code inside {4'h0, 4'h2, 4'h3, 4'h4, 4'h5}) else $error("bad code");
	chk_revert_one: assert property (
		watchdog_timeout && loader_state_code inside {4'h2, 4'h5}
		|-> ##[1:20] loader_state_code == 4'h3) else $error("no revert code 3");
	chk_revert_zero: assert property (
		watchdog_timeout && loader_state_code inside {4'h3, 4'h4}
		|-> ##[1:20] loader_state_code == 4'h5) else $error("no revert code 5");
	chk_code_hold: assert property (
		$past(loader_state_code) != 4'h0 && !watchdog_timeout && gap_r > LOAD_CYC + 8
		|-> $stable(loader_state_code)) else $error("code moved without load");
	chk_irq_quiet: assert property (
		!wr && !$past(wr) && !$past(wr, 2) && gap_r > LOAD_CYC + 8
		|-> $stable(irq)) else $error("irq moved without cause");
endmodule // image_upgrade_watchdog_chk
bind image_upgrade_watchdog image_upgrade_watchdog_chk #(.LOAD_CYC(LOAD_CYC)) i_chk
	(.clk(clk), .rst_n(rst_n), .reconfig_request_n(reconfig_request_n), .wr(wr), .rd(rd),
	.rdata(rdata),
	.watchdog_timeout(watchdog_timeout), .loader_state_code(loader_state_code), .irq(irq));

//--- dv/restart_keeper.sv
// Fabric logic model that keeps restarting the watchdog.
`timescale 1ns/1ps
module restart_keeper
(
	input wire logic clk, // Clock.
	input wire logic enable, // Watchdog enabled.
	output logic restart_n // Restart pulse, active low.
);
	int cnt = 0;
	initial
	begin
		restart_n = 1'b1;
	end
	// Three low cycles (300 ns) out of every twenty, only while enabled.
	always @(posedge clk)
	begin
		cnt <= (cnt + 1) % 20;
		restart_n <= !(enable && cnt < 3);
	end
endmodule // restart_keeper

//--- dv/image_upgrade_watchdog_test.sv
// Self-checking testbench of the upgrade watchdog.
`timescale 1ns/1ps
`include "upgrade_wd_map.svh"
module image_upgrade_watchdog_test;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sel = 1'b0, keep_en = 1'b1;
	logic shift_not_load = 1'b0, capture_not_update = 1'b1, shift_din = 1'b1;
	logic restart_n, timeout, irq;
	logic rcfg_n = 1'b1, crc_err = 1'b0;
	logic dout;
	logic [3:0] addr = 4'h0;
	logic [3:0] code;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	int fails = 0;
	int check_count = 0;
	image_upgrade_watchdog #(.OSC_DIV(2000), .LOAD_CYC(16)) i_image_upgrade_watchdog
	(
		.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.watchdog_restart_n(restart_n), .reconfig_request_n(rcfg_n), .image_select(sel),
		.crc_error_in(crc_err), .status_fault_n(1'b1), .shift_not_load(shift_not_load),
		.capture_not_update(capture_not_update), .shift_din(shift_din), .shift_dout(dout),
		.watchdog_timeout(timeout), .loader_state_code(code), .irq(irq)
	);
	restart_keeper i_restart_keeper (.clk(clk), .enable(keep_en), .restart_n(restart_n));
	initial
	begin
		forever #50 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	// Waits up to 2200 cycles for an expiry and judges whether one came.
	task automatic wait_to(input logic exp);
		int k;
		k = 0;
		while (timeout !== 1'b1 && k < 2200)
		begin
			@(posedge clk);
			#1;
			k++;
		end
		chk({31'h0, timeout}, {31'h0, exp});
	endtask
	task automatic code_is(input logic [3:0] c);
		#1;
		chk({28'h0, code}, {28'h0, c});
	endtask
	task automatic revert(input logic [3:0] c);
		wait_to(1'b1);
		repeat (3) @(posedge clk);
		code_is(c);
	endtask
	task automatic do_reset(input logic s);
		@(posedge clk);
		rst_n <= 1'b0;
		sel <= s;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		code_is(s ? 4'h4 : 4'h2);
	endtask
	task automatic t_boot();
		do_reset(1'b0);
		revert(4'h3);
		repeat (22) @(posedge clk);
		wr_reg(`ADDR_CTRL, 32'h0000_0011);
		keep_en <= 1'b0;
		rd_reg(`ADDR_PREV, 32'h1080_0000);
		$display("boot test done");
	endtask
	task automatic t_regs();
		wait_to(1'b0);
		rd_reg(`ADDR_CUR, 32'hE000_0001);
		rd_reg(`ADDR_IRQ_ST, 32'h1);
		wr_reg(`ADDR_IRQ_MASK, 32'h1);
		repeat (2) @(posedge clk);
		code_is(4'h3);
		chk({31'h0, irq}, 32'h1);
		wr_reg(`ADDR_IRQ_ST, 32'h1);
		repeat (2) @(posedge clk);
		#1;
		chk({31'h0, irq}, 32'h0);
		wr_reg(4'h7, 32'hFFFF_FFFF);
		rd_reg(4'h7, 32'h0);
		rd_reg(`ADDR_CTRL, 32'h0000_0011);
		$display("register test done");
	endtask
	task automatic t_chain();
		@(posedge clk);
		shift_din <= 1'b0;
		shift_not_load <= 1'b1;
		repeat (44) @(posedge clk);
		shift_din <= 1'b1;
		#1;
		chk({31'h0, dout}, 32'h0);
		repeat (44) @(posedge clk);
		shift_not_load <= 1'b0;
		capture_not_update <= 1'b0;
		#1;
		chk({31'h0, dout}, 32'h1);
		repeat (4) @(posedge clk);
		capture_not_update <= 1'b1;
		rd_reg(`ADDR_INREG, 32'h0000_3000);
		$display("chain test done");
	endtask
	task automatic t_src();
		repeat (20) @(posedge clk);
		rcfg_n <= 1'b0;
		crc_err <= 1'b1;
		repeat (6) @(posedge clk);
		rcfg_n <= 1'b1;
		crc_err <= 1'b0;
		code_is(4'h2);
		rd_reg(`ADDR_PREV, 32'h8140_0000);
		rd_reg(`ADDR_IRQ_ST, 32'hD);
		$display("source test done");
	endtask
	task automatic t_again();
		wr_reg(`ADDR_CTRL, 32'h1);
		keep_en <= 1'b1;
		revert(4'h5);
		$display("re-enable test done");
	endtask
	task automatic t_one();
		do_reset(1'b1);
		revert(4'h5);
		$display("image one test done");
	endtask
	task automatic test_done();
		$display("checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		#2000000;
		$display("BAD %0t: run hung", $time);
		fails++;
		test_done();
	end
	initial
	begin
		t_boot();
		t_regs();
		t_chain();
		t_again();
		t_src();
		t_one();
		test_done();
	end
endmodule // image_upgrade_watchdog_test
